// [core/adv_pkg.sv]
// Purpose: Constants and types for the auto-negotiation advertisement register bank.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Register offsets other than the advertisement word are local choices.
//
// Behaviour
// - Next-page capability bit 15 is read-only and reads zero.
// - Bit 8 advertises 100TX full duplex; writable, resets to one.
// - Bit 7 advertises 100TX half duplex; writable, resets to one.
// - Bit 5 advertises 10T half duplex; writable, resets to one.
// - Negotiation keeps old abilities until a restart is requested.
// - Selector bits 4:0 are read-only, fixed at 0x01.
// - Selector is five bits wide; only one code is ever presented.
package adv_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ADV_OFFSET = 12'h010;
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] ACTIVE_OFFSET = 12'h014;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int NEXT_PAGE_BIT = 15;
    localparam int REMOTE_FAULT_BIT = 13;
    localparam int ABILITY_LSB = 5;
    localparam int ABILITY_MSB = 8;
    localparam int RESTART_BIT = 9;
    localparam logic [4:0] SELECTOR_CODE = 5'h01;
    localparam logic [3:0] ABILITY_RESET = 4'hf;
    localparam logic REMOTE_FAULT_RESET = 1'b0;
    localparam logic NEXT_PAGE_VALUE = 1'b0;
    localparam logic [15:0] WRITE_MASK = 16'h21e0;
    localparam logic [15:0] ADV_RESET = 16'h01e1;

    typedef struct packed {
        logic remote_fault;
        logic [3:0] abilities;
    } adv_fields_type;

endpackage : adv_pkg

// [core/adv_word_reg.sv]
// Purpose: Holds one set of advertised fields with load strobe.
// Assumes: Synchronous load, asynchronous active-low reset.
// Notes: Read data comes straight from the flip-flops.
module adv_word_reg (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Load side
    input wire logic load,
    input wire adv_pkg::adv_fields_type load_data,
    // Stored value
    output adv_pkg::adv_fields_type held_ff
);
    import adv_pkg::*;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_ff <= '{remote_fault: REMOTE_FAULT_RESET, abilities: ABILITY_RESET};
        end else if (load) begin
            held_ff <= load_data;
        end
    end
endmodule // adv_word_reg

// [core/autoneg_advertisement_reg.sv]
// Purpose: Auto-negotiation advertisement register with restart-gated active copy.
// Assumes: APB master follows the usual setup and access phases.
// Notes: The negotiation engine reads the active copy, not the software copy.
module autoneg_advertisement_reg (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Negotiation side
    output logic [15:0] active_page,
    output logic restart_pulse
);
    import adv_pkg::*;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic access;
    logic wr_adv;
    logic wr_ctrl;
    logic restart_req;
    adv_fields_type soft_ff;
    adv_fields_type act_ff;
    adv_fields_type wr_fields;
    logic [31:0] nxt_prdata;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic restart_ff;
    logic complete;
    logic pready_ff;
    logic [15:0] active_page_ff;

    function automatic logic [15:0] pack_page(input adv_fields_type f);
        logic [15:0] w;
        w = 16'h0000;
        w[NEXT_PAGE_BIT] = NEXT_PAGE_VALUE;
        w[REMOTE_FAULT_BIT] = f.remote_fault;
        w[ABILITY_MSB:ABILITY_LSB] = f.abilities;
        w[4:0] = SELECTOR_CODE;
        return w;
    endfunction

    function automatic logic known_addr(input logic [11:0] a);
        return (a == ADV_OFFSET) || (a == CTRL_OFFSET) || (a == ACTIVE_OFFSET);
    endfunction

    assign access = psel && penable;
    // A transfer completes at the edge where the slave shows pready in its access
    // phase. Writes act at that edge only, so a restart cannot be counted twice
    // while the master still holds its request through the wait state.
    assign complete = access && pready_ff;
    assign wr_adv = complete && pwrite && (paddr == ADV_OFFSET);
    assign wr_ctrl = complete && pwrite && (paddr == CTRL_OFFSET);
    // Only the restart bit acts; it is self-clearing.
    assign restart_req = wr_ctrl && pwdata[RESTART_BIT];
    // Reserved, next-page and selector bits ignore writes.
    assign wr_fields = '{remote_fault: pwdata[REMOTE_FAULT_BIT],
                         abilities: pwdata[ABILITY_MSB:ABILITY_LSB]};

    // ------------------------------------------------------------------
    // Software copy
    // ------------------------------------------------------------------
    adv_word_reg u_soft (
        .pclk(pclk),
        .presetn(presetn),
        .load(wr_adv),
        .load_data(wr_fields),
        .held_ff(soft_ff)
    );

    // ------------------------------------------------------------------
    // Active copy, loaded only on a restart request
    // ------------------------------------------------------------------
    // A write and restart in one access cannot collide: they hit different words.
    adv_word_reg u_active (
        .pclk(pclk),
        .presetn(presetn),
        .load(restart_req),
        .load_data(soft_ff),
        .held_ff(act_ff)
    );

    // The negotiation side sees the active copy one cycle after it loads; the
    // pulse tells it that a fresh page is about to stand on active_page.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_ff <= 1'b0;
        end else begin
            restart_ff <= restart_req;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_page_ff <= ADV_RESET;
        end else begin
            active_page_ff <= pack_page(act_ff);
        end
    end
    assign active_page = active_page_ff;
    assign restart_pulse = restart_ff;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            ADV_OFFSET: nxt_prdata[15:0] = pack_page(soft_ff);
            ACTIVE_OFFSET: nxt_prdata[15:0] = pack_page(act_ff);
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end

    // Registered reads need one wait state: pready rises in the second access cycle
    // and stands for that cycle only, so every transfer takes exactly one wait state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= access && !pready_ff;
        end
    end

    // Read data are captured in the wait state, while the address still stands,
    // and are held unchanged through the completing cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (access && !pready_ff) begin
            prdata_ff <= nxt_prdata;
        end
    end

    // An unmapped address completes normally but flags an error and changes nothing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= access && !pready_ff && !known_addr(paddr);
        end
    end
    assign pready = pready_ff;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Register contents as software reads them.
    AST_SELECTOR: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && paddr == ADV_OFFSET |=> prdata[4:0] == 5'h01)
        else $error("selector not 0x01");
    AST_NP_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && paddr == ADV_OFFSET |=> prdata[15] == 1'b0)
        else $error("next page bit set");
    AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite |=> (prdata[14] == 1'b0 && prdata[12:9] == 4'h0))
        else $error("reserved bits nonzero");
    AST_READ_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite |=> prdata[31:16] == 16'h0000)
        else $error("upper half of read word nonzero");
    AST_READ_ACTIVE: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && paddr == ACTIVE_OFFSET |=> prdata[15:0] == active_page)
        else $error("active page readback differs from the page in use");

    // The software copy takes writes and nothing else.
    AST_WRITE_AB: assert property (@(posedge pclk) disable iff (!presetn)
        wr_adv |=> soft_ff.abilities[3] == $past(pwdata[8]) &&
                   soft_ff.abilities[2] == $past(pwdata[7]))
        else $error("100TX abilities not written");
    AST_WRITE_10T: assert property (@(posedge pclk) disable iff (!presetn)
        wr_adv |=> soft_ff.abilities[1:0] == $past(pwdata[6:5]))
        else $error("10T abilities not written");
    AST_WRITE_HALF: assert property (@(posedge pclk) disable iff (!presetn)
        wr_adv |=> soft_ff.abilities[0] == $past(pwdata[5]))
        else $error("10T half bit not written");
    AST_HALF100: assert property (@(posedge pclk) disable iff (!presetn)
        wr_adv |=> soft_ff.abilities[2] == $past(pwdata[7]))
        else $error("100TX half bit not written");
    AST_RFAULT: assert property (@(posedge pclk) disable iff (!presetn)
        wr_adv |=> soft_ff.remote_fault == $past(pwdata[13]))
        else $error("remote fault not written");
    AST_SOFT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_adv |=> soft_ff == $past(soft_ff))
        else $error("software copy changed without a write");

    // The active copy and the negotiation side.
    AST_HOLD_ACTIVE: assert property (@(posedge pclk) disable iff (!presetn)
        !restart_req |=> act_ff == $past(act_ff))
        else $error("active copy changed without restart");
    AST_RESTART_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        restart_req |=> ##1 active_page == pack_page($past(soft_ff, 2)))
        else $error("restart did not load abilities");
    AST_PAGE_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
        active_page == pack_page($past(act_ff)))
        else $error("active page does not follow the active copy");
    AST_RESTART_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        restart_req |=> restart_pulse)
        else $error("no restart pulse after a restart request");
    AST_PULSE_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        restart_pulse |=> !restart_pulse)
        else $error("restart pulse longer than one cycle");
    AST_PAGE_SEL: assert property (@(posedge pclk) disable iff (!presetn)
        active_page[4:0] == SELECTOR_CODE)
        else $error("active selector wrong");

    // The bus handshake.
    AST_PREADY_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready_ff |=> pready_ff)
        else $error("no ready after the wait state");
    AST_PREADY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        pready_ff |=> !pready_ff)
        else $error("ready stood longer than one cycle");
    AST_SLVERR_MAP: assert property (@(posedge pclk) disable iff (!presetn)
        access && pready_ff |-> pslverr == !known_addr(paddr))
        else $error("error flag does not match the address map");
endmodule // autoneg_advertisement_reg

// [testbench/adv_partner_model.sv]
// Purpose: Negotiation-side partner that latches the page it would send.
// Assumes: The page is settled one cycle after the restart pulse.
// Notes: Later writes to the software copy must not alter what was sent.
module adv_partner_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Negotiation side
    input wire logic restart_pulse,
    input wire logic [15:0] active_page,
    // Observed
    output logic [15:0] sent_page_ff,
    output logic [7:0] restart_count_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pend_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff <= 1'b0;
            sent_page_ff <= 16'h0000;
            restart_count_ff <= 8'h00;
        end else begin
            pend_ff <= restart_pulse;
            if (pend_ff) begin
                sent_page_ff <= active_page;
                restart_count_ff <= restart_count_ff + 8'h01;
            end
        end
    end
endmodule // adv_partner_model

// [testbench/autoneg_advertisement_reg_tb.sv]
// Purpose: Self-checking bench for the advertisement register bank.
// Assumes: APB slave answers with pready; page applied on restart.
// Notes: Register model is kept here with plain vectors and counts.
module autoneg_advertisement_reg_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import adv_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, restart_pulse;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [15:0] active_page, sent_page, sw_m, act_m;
    logic [7:0] restarts;
    int err_total = 0;
    int checked = 0;
    int nrst = 0;
    int cycles = 0;
    autoneg_advertisement_reg u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .active_page(active_page),
        .restart_pulse(restart_pulse));
    adv_partner_model u_partner (.pclk(pclk), .presetn(presetn), .restart_pulse(restart_pulse),
        .active_page(active_page), .sent_page_ff(sent_page), .restart_count_ff(restarts));
    task automatic test_done();
        if (err_total == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk("prdata", {16'h0000, exp}, r);
        chk("pslverr", {31'h0, experr}, {31'h0, e});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, wd, r, e);
    endtask
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 5000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sw_m = 16'h01e1;
        act_m = 16'h01e1;
        void'($urandom(32'hbf90));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ADV_OFFSET, sw_m, 1'b0);
        rd_chk(ACTIVE_OFFSET, act_m, 1'b0);
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $urandom();
            // Reserved bits go back as they were last read, as software must do.
            d[14] = sw_m[14];
            d[12:9] = sw_m[12:9];
            wr(ADV_OFFSET, d);
            // Only remote fault and the four abilities take writes.
            sw_m = (d[15:0] & 16'h21e0) | 16'h0001;
            rd_chk(ADV_OFFSET, sw_m, 1'b0);
            chk("active_page", {16'h0, act_m}, {16'h0, active_page});
            if (i % 3 != 0) begin
                wr(CTRL_OFFSET, 32'h00000200);
                act_m = sw_m;
                nrst++;
                repeat (3) @(posedge pclk);
                chk("active_page", {16'h0, act_m}, {16'h0, active_page});
                chk("sent_page", {16'h0, act_m}, {16'h0, sent_page});
                chk("restarts", nrst, {24'h0, restarts});
            end
        end
        // Reset in mid-run: both copies, the page and the partner return to idle.
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        sw_m = 16'h01e1;
        act_m = 16'h01e1;
        nrst = 0;
        rd_chk(ADV_OFFSET, sw_m, 1'b0);
        rd_chk(ACTIVE_OFFSET, act_m, 1'b0);
        chk("active_page", {16'h0, act_m}, {16'h0, active_page});
        chk("restarts", nrst, {24'h0, restarts});
        wr(CTRL_OFFSET, 32'h00000200);
        nrst++;
        repeat (3) @(posedge pclk);
        chk("sent_page", {16'h0, act_m}, {16'h0, sent_page});
        chk("restarts", nrst, {24'h0, restarts});
        rd_chk(CTRL_OFFSET, 16'h0000, 1'b0);
        rd_chk(12'h0fc, 16'h0000, 1'b1);
        test_done();
    end
endmodule // autoneg_advertisement_reg_tb
